// ### bsg_defines.svh
`ifndef BSG_DEFINES_SVH
`define BSG_DEFINES_SVH

// Clock period and the derived cycle counts (least times round up).
`define BSG_CLK_NS 4
`define BSG_MIN_PULSE_MS 1
`define BSG_MIN_PULSE_CYC \
	((`BSG_MIN_PULSE_MS * 1000000 + `BSG_CLK_NS - 1) / `BSG_CLK_NS)
`define BSG_POR_US 8
`define BSG_POR_CYC ((`BSG_POR_US * 1000 + `BSG_CLK_NS - 1) / `BSG_CLK_NS)
`define BSG_POR_W 12

// Register byte offsets.
`define BSG_REG_STATUS 8'h00
`define BSG_REG_MASK 8'h04
`define BSG_REG_STATE 8'h08
`define BSG_REG_CTRL 8'h0C

// Event bits, shared by status and mask.
`define BSG_EV_W 6
`define BSG_EV_SLOT0 0
`define BSG_EV_FRONT 1
`define BSG_EV_BACK 2
`define BSG_EV_READ 3
`define BSG_EV_SHORT 4
`define BSG_EV_DOWN 5
`define BSG_CTRL_LAMP_TEST 0

// Reset values.
`define BSG_STATUS_RST 6'h00
`define BSG_MASK_RST 6'h00
`define BSG_CTRL_RST 1'h0
`define BSG_XBAR_RST_VAL 1'h1
`define BSG_SYNC_IDLE 34'h63

`endif

// ### bsg_pkg.sv
package bsg_pkg;

	typedef enum logic {
		bsg_por_hold,
		bsg_por_run
	} bsg_por_state_t;

endpackage

// ### bsg_core_if.sv
`timescale 1ns/1ps
interface bsg_core_if;
	logic wr_pulse;
	logic rd_pulse;
	logic wr_bit;
	logic por_hold;
	logic xbar_rst;
	logic read_seen;
	logic [15:0] err_vec;
	logic lamp_test;
	logic [2:0] lamps;
	logic [2:0] err_rise;

	modport latch (
		input wr_pulse, rd_pulse, wr_bit, por_hold,
		output xbar_rst, read_seen
	);
	modport lamp (
		input err_vec, lamp_test,
		output lamps, err_rise
	);
endinterface

// ### bsg_xbar_latch.sv
`timescale 1ns/1ps
module bsg_xbar_latch (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Controller side
	bsg_core_if.latch cif
);
	`include "bsg_defines.svh"

	logic held;

	// Only board power-on and controller writes set this; the controller's own reset never
	// reaches it, so a soft restart keeps the crossbars where they were.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			held <= `BSG_XBAR_RST_VAL;
		end else if (cif.wr_pulse) begin
			held <= cif.wr_bit;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cif.xbar_rst <= 1'h1;
		end else begin
			cif.xbar_rst <= held | cif.por_hold;
		end
	end

	// A read leaves the latch as it was and is only reported.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cif.read_seen <= 1'h0;
		end else begin
			cif.read_seen <= cif.rd_pulse;
		end
	end

	chk_write_one_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
		cif.wr_pulse && cif.wr_bit |-> ##2 cif.xbar_rst)
		else $error("write of one did not assert crossbar reset");
	chk_write_zero_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
		cif.wr_pulse && !cif.wr_bit ##1 !cif.por_hold |=> !cif.xbar_rst)
		else $error("write of zero did not release crossbar reset");
	chk_latch_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
		!cif.wr_pulse |=> $stable(held))
		else $error("crossbar reset latch changed without a write");
endmodule

// ### bsg_err_lamp.sv
`timescale 1ns/1ps
module bsg_err_lamp (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Error sources and lamps
	bsg_core_if.lamp cif
);
	logic [2:0] grp;
	logic [2:0] grp_d;

	// Slot 0 alone, slots 1 to 7 front row, slots 8 to 15 back row.
	assign grp = {|cif.err_vec[15:8], |cif.err_vec[7:1], cif.err_vec[0]};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cif.lamps <= 3'h0;
			grp_d <= 3'h0;
			cif.err_rise <= 3'h0;
		end else begin
			cif.lamps <= grp | {3{cif.lamp_test}};
			grp_d <= grp;
			cif.err_rise <= grp & ~grp_d;
		end
	end

	chk_row_lamps: assert property (@(posedge clk_sys) disable iff (!nrst)
		grp[1] && grp[2] |=> cif.lamps[1] && cif.lamps[2])
		else $error("row lamp dark while a row module reports error");
endmodule

// ### bsg_glue.sv
// Behaviour
// - A controller write with data bit 0 high asserts crossbar reset.
// - A controller write with data bit 0 low releases crossbar reset.
// - Controller reset never changes the crossbar reset latch.
// - Power-on reset also asserts crossbar reset.
// - Slot 0 reset and analyse come from upstream; its error goes up.
// - Slots 1-15 and controller take services from upstream or slot 0.
// - Slot 0 services are repeated on downstream pins for chaining.
// - Slot 0 subsystem controls are repeated on the subsystem pins.
// - Board pins are active low, module sockets active high.
// - Controller error stays out of the module error network.
// - Only slot 0 has subsystem pins, valid with such a module.
// - Lamps show errors of slot 0, front row and back row.
// - Controller links 0,3 feed crossbars, link 1 input, 2 output.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "bsg_defines.svh"
module bsg_glue #(
	parameter int MIN_PULSE_CYC = `BSG_MIN_PULSE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Upstream services
	input wire logic up_reset_n,
	input wire logic up_analyse_n,
	output logic up_error_n,
	// Downstream chain
	output logic down_reset_n,
	output logic down_analyse_n,
	input wire logic down_error_n,
	// Subsystem connector
	output logic ss_reset_n,
	output logic ss_analyse_n,
	input wire logic ss_error_n,
	// Slot 0 module
	output logic slot0_reset,
	output logic slot0_analyse,
	input wire logic slot0_error,
	input wire logic slot0_sub_reset,
	input wire logic slot0_sub_analyse,
	output logic slot0_sub_error,
	// Slots 1 to 15 and switch controller
	output logic grp_reset,
	output logic grp_analyse,
	input wire logic [15:1] slot_error,
	output logic ctl_reset,
	// Board switch: high takes the group from slot 0's subsystem
	input wire logic sub_select,
	// Controller memory strobes
	input wire logic ctl_wr,
	input wire logic ctl_rd,
	input wire logic ctl_d0,
	// Crossbar reset
	output logic xbar_reset,
	// Lamps
	output logic slot0_error_lamp,
	output logic front_row_error_lamp,
	output logic back_row_error_lamp,
	// Controller links
	input wire logic [3:0] ctl_link_tx,
	output logic [3:0] ctl_link_rx,
	input wire logic first_crossbar_cfg_tx,
	output logic first_crossbar_cfg_rx,
	input wire logic second_crossbar_cfg_tx,
	output logic second_crossbar_cfg_rx,
	input wire logic config_in_link_rx,
	output logic config_in_link_tx,
	input wire logic config_out_link_rx,
	output logic config_out_link_tx
);
	localparam int SW = 34;
	localparam int PW = $clog2(MIN_PULSE_CYC + 1);

	bsg_core_if cif ();

	logic [SW-1:0] raw;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic up_rst;
	logic up_ana;
	logic sel;
	logic sub_rst;
	logic sub_ana;
	logic ss_err;
	logic down_err;
	logic slot0_err;
	logic [15:1] slot_err;
	logic grp_err;
	logic wr_d;
	logic rd_d;
	logic down_err_d;
	logic [1:0] svc_low;
	logic [1:0] svc_low_d;
	logic [1:0] short_hit;
	bsg_pkg::bsg_por_state_t por_st;
	logic [`BSG_POR_W-1:0] por_cnt;
	logic [`BSG_EV_W-1:0] status;
	logic [`BSG_EV_W-1:0] mask;
	logic ctrl_lamp_test;
	logic [`BSG_EV_W-1:0] events;
	logic [`BSG_EV_W-1:0] next_status;

	// Every pin input except the register port is asynchronous to clk_sys.
	assign raw = {ctl_link_tx, first_crossbar_cfg_tx, second_crossbar_cfg_tx,
		config_in_link_rx, config_out_link_rx, slot_error, slot0_error,
		ctl_d0, ctl_rd, ctl_wr, down_error_n, ss_error_n, slot0_sub_analyse,
		slot0_sub_reset, sub_select, up_analyse_n, up_reset_n};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1 <= `BSG_SYNC_IDLE;
			sync2 <= `BSG_SYNC_IDLE;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	// Board pins are active low, turned active high here.
	assign up_rst = ~sync2[0];
	assign up_ana = ~sync2[1];
	assign sel = sync2[2];
	assign sub_rst = sync2[3];
	assign sub_ana = sync2[4];
	assign ss_err = ~sync2[5];
	assign down_err = ~sync2[6];
	assign slot0_err = sync2[10];
	assign slot_err = sync2[25:11];
	assign grp_err = |slot_err;

	// Power-on sequencer: holds the crossbars in reset for a fixed time.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			por_st <= bsg_pkg::bsg_por_hold;
			por_cnt <= 12'h000;
		end else begin
			case (por_st)
				bsg_pkg::bsg_por_hold: begin
					if (por_cnt == `BSG_POR_W'(`BSG_POR_CYC - 1)) begin
						por_st <= bsg_pkg::bsg_por_run;
					end else begin
						por_cnt <= por_cnt + 12'h001;
					end
				end
				bsg_pkg::bsg_por_run: begin
					por_st <= bsg_pkg::bsg_por_run;
				end
				default: begin
					por_st <= bsg_pkg::bsg_por_hold;
				end
			endcase
		end
	end

	// Memory strobe edges; data bit 0 settles before the strobe rises.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_d <= 1'h0;
			rd_d <= 1'h0;
		end else begin
			wr_d <= sync2[7];
			rd_d <= sync2[8];
		end
	end

	assign cif.wr_pulse = sync2[7] & ~wr_d;
	assign cif.wr_bit = sync2[9];
	// Reads are flagged, the latch ignores them.
	assign cif.rd_pulse = sync2[8] & ~rd_d;
	assign cif.por_hold = (por_st == bsg_pkg::bsg_por_hold);
	assign cif.err_vec = {slot_err, slot0_err};
	assign cif.lamp_test = ctrl_lamp_test;

	bsg_xbar_latch u_latch (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cif(cif.latch)
	);

	bsg_err_lamp u_lamp (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cif(cif.lamp)
	);

	assign xbar_reset = cif.xbar_rst;
	assign slot0_error_lamp = cif.lamps[0];
	assign front_row_error_lamp = cif.lamps[1];
	assign back_row_error_lamp = cif.lamps[2];

	// Reset and analyse routing. Everything sits in reset during nrst.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			slot0_reset <= 1'h1;
			slot0_analyse <= 1'h0;
			grp_reset <= 1'h1;
			grp_analyse <= 1'h0;
			ctl_reset <= 1'h1;
		end else begin
			slot0_reset <= up_rst;
			slot0_analyse <= up_ana;
			grp_reset <= sel ? sub_rst : up_rst;
			grp_analyse <= sel ? sub_ana : up_ana;
			ctl_reset <= sel ? sub_rst : up_rst;
		end
	end

	// Repeated pins toward the chain and the subsystem connector.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			down_reset_n <= 1'h0;
			down_analyse_n <= 1'h1;
			ss_reset_n <= 1'h0;
			ss_analyse_n <= 1'h1;
		end else begin
			down_reset_n <= ~up_rst;
			down_analyse_n <= ~up_ana;
			// Meaningful only with a subsystem-capable module in slot 0.
			ss_reset_n <= ~sub_rst;
			ss_analyse_n <= ~sub_ana;
		end
	end

	// Error network. The controller has no error input here at all.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			up_error_n <= 1'h1;
			slot0_sub_error <= 1'h0;
		end else begin
			up_error_n <= ~(slot0_err | down_err | (~sel & grp_err));
			slot0_sub_error <= ss_err | (sel & grp_err);
		end
	end

	// Link wires are re-timed at 250 MHz; the added 12 ns of latency is
	// small against a 20 MHz link bit.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctl_link_rx <= 4'h0;
			first_crossbar_cfg_rx <= 1'h0;
			second_crossbar_cfg_rx <= 1'h0;
			config_in_link_tx <= 1'h0;
			config_out_link_tx <= 1'h0;
		end else begin
			ctl_link_rx <= {sync2[28], sync2[26], sync2[27], sync2[29]};
			first_crossbar_cfg_rx <= sync2[30];
			second_crossbar_cfg_rx <= sync2[33];
			config_in_link_tx <= sync2[31];
			config_out_link_tx <= sync2[32];
		end
	end

	// Upstream pulse width watch, one counter per service line.
	assign svc_low = {up_ana, up_rst};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			svc_low_d <= 2'h0;
			down_err_d <= 1'h0;
		end else begin
			svc_low_d <= svc_low;
			down_err_d <= down_err;
		end
	end

	for (genvar k = 0; k < 2; k++) begin : g_width
		logic [PW-1:0] cnt;
		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst) begin
				cnt <= {PW{1'b0}};
			end else if (!svc_low[k]) begin
				cnt <= {PW{1'b0}};
			end else if (cnt != PW'(MIN_PULSE_CYC)) begin
				cnt <= cnt + PW'(1);
			end
		end
		assign short_hit[k] = svc_low_d[k] & ~svc_low[k] &
			(cnt < PW'(MIN_PULSE_CYC));
	end

	// Interrupt events.
	always_comb begin
		events = {`BSG_EV_W{1'b0}};
		events[`BSG_EV_SLOT0] = cif.err_rise[0];
		events[`BSG_EV_FRONT] = cif.err_rise[1];
		events[`BSG_EV_BACK] = cif.err_rise[2];
		events[`BSG_EV_READ] = cif.read_seen;
		events[`BSG_EV_SHORT] = |short_hit;
		events[`BSG_EV_DOWN] = down_err & ~down_err_d;
	end

	// Write-one-to-clear; an event in the clearing cycle survives.
	always_comb begin
		next_status = status;
		if (reg_wr && reg_addr == `BSG_REG_STATUS) begin
			next_status = status & ~reg_wdata[`BSG_EV_W-1:0];
		end
		next_status = next_status | events;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status <= `BSG_STATUS_RST;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mask <= `BSG_MASK_RST;
			ctrl_lamp_test <= `BSG_CTRL_RST;
		end else if (reg_wr) begin
			if (reg_addr == `BSG_REG_MASK) begin
				mask <= reg_wdata[`BSG_EV_W-1:0];
			end
			if (reg_addr == `BSG_REG_CTRL) begin
				ctrl_lamp_test <= reg_wdata[`BSG_CTRL_LAMP_TEST];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'h0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`BSG_REG_STATUS: reg_rdata <= {26'h0, status};
				`BSG_REG_MASK: reg_rdata <= {26'h0, mask};
				`BSG_REG_STATE: reg_rdata <= {24'h000000, cif.por_hold,
					cif.xbar_rst, sel, grp_reset, slot0_reset, cif.lamps};
				`BSG_REG_CTRL: reg_rdata <= {31'h0, ctrl_lamp_test};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	chk_slot0_from_up: assert property (@(posedge clk_sys) disable iff (!nrst)
		!up_reset_n [*3] |=> slot0_reset)
		else $error("slot 0 not in reset while upstream reset held");
	chk_group_select: assert property (@(posedge clk_sys) disable iff (!nrst)
		sel && sub_rst |=> grp_reset && ctl_reset)
		else $error("group did not follow slot 0 subsystem reset");
	chk_down_chain: assert property (@(posedge clk_sys) disable iff (!nrst)
		down_reset_n == !slot0_reset && down_analyse_n == !slot0_analyse)
		else $error("downstream pins differ from slot 0 services");
	chk_sub_connector: assert property (@(posedge clk_sys) disable iff (!nrst)
		sub_rst |=> !ss_reset_n)
		else $error("subsystem connector reset not driven low");
	chk_err_isolated: assert property (@(posedge clk_sys) disable iff (!nrst)
		!slot0_err && !down_err && (sel || !grp_err) |=> up_error_n)
		else $error("upstream error asserted with no module error");
	chk_link_route: assert property (@(posedge clk_sys) disable iff (!nrst)
		ctl_link_tx[0] [*3] |=> first_crossbar_cfg_rx)
		else $error("controller link 0 not routed to first crossbar");
	chk_por_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
		cif.por_hold |=> xbar_reset)
		else $error("crossbar reset low during power-on hold");
	chk_status_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
		events[`BSG_EV_SHORT] |=> status[`BSG_EV_SHORT])
		else $error("status event lost");
endmodule

// ### bsg_up_model.sv
`timescale 1ns/1ps
module bsg_up_model #(
	parameter int HOLD_CYC = 24
) (
	// Clock
	input wire logic clk_sys,
	// Upstream services
	output logic up_reset_n,
	output logic up_analyse_n,
	// Controller memory strobes
	output logic ctl_wr,
	output logic ctl_rd,
	output logic ctl_d0,
	// Configuration master
	output logic config_in_link_rx
);
	initial begin
		up_reset_n = 1'h1;
		up_analyse_n = 1'h1;
		ctl_wr = 1'h0;
		ctl_rd = 1'h0;
		ctl_d0 = 1'h0;
		config_in_link_rx = 1'h0;
	end
	// Every level is held for HOLD_CYC cycles, so no low pulse is short.
	task automatic svc_level(input logic rst_n, input logic ana_n);
		@(posedge clk_sys);
		up_reset_n <= rst_n;
		up_analyse_n <= ana_n;
		repeat (HOLD_CYC - 1) @(posedge clk_sys);
	endtask
	// Data settles well before the strobe rises and stays until the next write.
	task automatic ctl_write(input logic d0);
		@(posedge clk_sys);
		ctl_d0 <= d0;
		repeat (3) @(posedge clk_sys);
		ctl_wr <= 1'h1;
		repeat (3) @(posedge clk_sys);
		ctl_wr <= 1'h0;
		repeat (3) @(posedge clk_sys);
	endtask
	// Deliberately short upstream reset pulse, only to exercise the watch.
	task automatic svc_pulse(input int n);
		@(posedge clk_sys);
		up_reset_n <= 1'h0;
		repeat (n) @(posedge clk_sys);
		up_reset_n <= 1'h1;
	endtask
	// A read the controller must never make; used only to see it flagged.
	task automatic ctl_read();
		@(posedge clk_sys);
		ctl_rd <= 1'h1;
		repeat (3) @(posedge clk_sys);
		ctl_rd <= 1'h0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic cfg_bit(input logic b);
		@(posedge clk_sys);
		config_in_link_rx <= b;
	endtask
endmodule

// ### bsg_glue_tb_top.sv
`timescale 1ns/1ps
`include "bsg_defines.svh"
module bsg_glue_tb_top;
	localparam int POR = `BSG_POR_CYC;
	logic clk_sys, nrst, reg_wr, reg_rd, irq;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, lfsr_st, rd;
	logic up_reset_n, up_analyse_n, up_error_n;
	logic down_reset_n, down_analyse_n, down_error_n;
	logic ss_reset_n, ss_analyse_n, ss_error_n;
	logic slot0_reset, slot0_analyse, slot0_error, slot0_sub_reset;
	logic slot0_sub_analyse, slot0_sub_error, grp_reset, grp_analyse;
	logic [15:1] slot_error;
	logic ctl_reset, sub_select, ctl_wr, ctl_rd, ctl_d0, xbar_reset;
	logic slot0_error_lamp, front_row_error_lamp, back_row_error_lamp;
	logic [3:0] ctl_link_tx, ctl_link_rx;
	logic first_crossbar_cfg_tx, first_crossbar_cfg_rx;
	logic second_crossbar_cfg_tx, second_crossbar_cfg_rx;
	logic config_in_link_rx, config_in_link_tx;
	logic config_out_link_rx, config_out_link_tx;
	int mismatches, checks_done;

	bsg_glue #(.MIN_PULSE_CYC(20)) i_bsg_glue (
		.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .up_reset_n(up_reset_n),
		.up_analyse_n(up_analyse_n), .up_error_n(up_error_n),
		.down_reset_n(down_reset_n), .down_analyse_n(down_analyse_n),
		.down_error_n(down_error_n), .ss_reset_n(ss_reset_n),
		.ss_analyse_n(ss_analyse_n), .ss_error_n(ss_error_n),
		.slot0_reset(slot0_reset), .slot0_analyse(slot0_analyse),
		.slot0_error(slot0_error), .slot0_sub_reset(slot0_sub_reset),
		.slot0_sub_analyse(slot0_sub_analyse),
		.slot0_sub_error(slot0_sub_error), .grp_reset(grp_reset),
		.grp_analyse(grp_analyse), .slot_error(slot_error),
		.ctl_reset(ctl_reset), .sub_select(sub_select), .ctl_wr(ctl_wr),
		.ctl_rd(ctl_rd), .ctl_d0(ctl_d0), .xbar_reset(xbar_reset),
		.slot0_error_lamp(slot0_error_lamp),
		.front_row_error_lamp(front_row_error_lamp),
		.back_row_error_lamp(back_row_error_lamp),
		.ctl_link_tx(ctl_link_tx), .ctl_link_rx(ctl_link_rx),
		.first_crossbar_cfg_tx(first_crossbar_cfg_tx),
		.first_crossbar_cfg_rx(first_crossbar_cfg_rx),
		.second_crossbar_cfg_tx(second_crossbar_cfg_tx),
		.second_crossbar_cfg_rx(second_crossbar_cfg_rx),
		.config_in_link_rx(config_in_link_rx),
		.config_in_link_tx(config_in_link_tx),
		.config_out_link_rx(config_out_link_rx),
		.config_out_link_tx(config_out_link_tx)
	);
	bsg_up_model #(.HOLD_CYC(24)) i_bsg_up_model (
		.clk_sys(clk_sys), .up_reset_n(up_reset_n),
		.up_analyse_n(up_analyse_n), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
		.ctl_d0(ctl_d0), .config_in_link_rx(config_in_link_rx)
	);

	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Group services follow slot 0's subsystem only when the switch says so.
	function automatic logic exp_grp(input logic sel, input logic sub,
		input logic up_n);
		return sel ? sub : ~up_n;
	endfunction
	function automatic logic exp_up_err_n(input logic s0, input logic dn_n,
		input logic sel, input logic [15:1] se);
		return ~(s0 | ~dn_n | (~sel & (|se)));
	endfunction

	task automatic close_out();
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t pin got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1;
		d = reg_rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	initial begin
		#200000;
		mismatches++;
		close_out();
	end

	initial begin
		mismatches = 0;
		checks_done = 0;
		lfsr_st = 32'h00004DCF;
		nrst = 1'h0;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{slot0_error, slot0_sub_reset, slot0_sub_analyse, sub_select} = '0;
		{down_error_n, ss_error_n} = 2'h3;
		slot_error = '0;
		ctl_link_tx = '0;
		{first_crossbar_cfg_tx, second_crossbar_cfg_tx} = '0;
		config_out_link_rx = 1'h0;
		settle(2);
		chk_pin(xbar_reset, 1'h1);
		chk_pin(slot0_reset, 1'h1);
		@(posedge clk_sys);
		@(posedge clk_sys);
		nrst <= 1'h1;
		reg_read(`BSG_REG_STATUS, rd);
		chk_word(rd, 32'h00000000);
		reg_read(`BSG_REG_MASK, rd);
		chk_word(rd, 32'h00000000);
		reg_read(`BSG_REG_CTRL, rd);
		chk_word(rd, 32'h00000000);
		// The latch takes the write, but power-on hold still wins.
		i_bsg_up_model.ctl_write(1'h0);
		chk_pin(xbar_reset, 1'h1);
		settle(POR);
		chk_pin(xbar_reset, 1'h0);
		i_bsg_up_model.ctl_write(1'h1);
		settle(20);
		chk_pin(xbar_reset, 1'h1);
		i_bsg_up_model.ctl_write(1'h0);
		chk_pin(xbar_reset, 1'h0);
		i_bsg_up_model.svc_level(1'h0, 1'h1);
		#1;
		chk_pin(ctl_reset, 1'h1);
		chk_pin(xbar_reset, 1'h0);
		for (int i = 0; i < 30; i++) begin
			lfsr_st = lfsr_next(lfsr_st);
			@(posedge clk_sys);
			sub_select <= lfsr_st[0];
			slot0_sub_reset <= lfsr_st[1];
			slot0_sub_analyse <= lfsr_st[2];
			slot0_error <= lfsr_st[3];
			down_error_n <= lfsr_st[4];
			ss_error_n <= lfsr_st[5];
			// First two passes hit the last front-row and first back-row slot.
			slot_error <= (i < 2) ? (15'h0040 << i) : lfsr_st[20:6];
			ctl_link_tx <= lfsr_st[24:21];
			first_crossbar_cfg_tx <= lfsr_st[25];
			second_crossbar_cfg_tx <= lfsr_st[26];
			config_out_link_rx <= lfsr_st[27];
			i_bsg_up_model.cfg_bit(lfsr_st[28]);
			i_bsg_up_model.svc_level(lfsr_st[29], lfsr_st[30]);
			#1;
			chk_pin(slot0_reset, ~up_reset_n);
			chk_pin(slot0_analyse, ~up_analyse_n);
			chk_pin(grp_reset, exp_grp(sub_select, slot0_sub_reset,
				up_reset_n));
			chk_pin(grp_analyse, exp_grp(sub_select, slot0_sub_analyse,
				up_analyse_n));
			chk_pin(ctl_reset, exp_grp(sub_select, slot0_sub_reset,
				up_reset_n));
			chk_pin(down_reset_n, up_reset_n);
			chk_pin(down_analyse_n, up_analyse_n);
			chk_pin(ss_reset_n, ~slot0_sub_reset);
			chk_pin(ss_analyse_n, ~slot0_sub_analyse);
			chk_pin(up_error_n, exp_up_err_n(slot0_error, down_error_n,
				sub_select, slot_error));
			chk_pin(slot0_sub_error, ~ss_error_n |
				(sub_select & (|slot_error)));
			chk_pin(slot0_error_lamp, slot0_error);
			chk_pin(front_row_error_lamp, |slot_error[7:1]);
			chk_pin(back_row_error_lamp, |slot_error[15:8]);
			chk_word({28'h0, ctl_link_rx}, {28'h0, second_crossbar_cfg_tx,
				config_out_link_rx, config_in_link_rx,
				first_crossbar_cfg_tx});
			chk_word({28'h0, first_crossbar_cfg_rx, second_crossbar_cfg_rx,
				config_in_link_tx, config_out_link_tx}, {28'h0,
				ctl_link_tx[0], ctl_link_tx[3], ctl_link_tx[1],
				ctl_link_tx[2]});
		end
		@(posedge clk_sys);
		{slot0_error, slot_error, sub_select} <= '0;
		{down_error_n, ss_error_n} <= 2'h3;
		i_bsg_up_model.svc_level(1'h1, 1'h1);
		reg_write(`BSG_REG_STATUS, 32'h0000003F);
		reg_read(`BSG_REG_STATUS, rd);
		chk_word(rd, 32'h00000000);
		reg_write(`BSG_REG_MASK, 32'h00000001);
		slot0_error <= 1'h1;
		settle(6);
		chk_pin(irq, 1'h1);
		reg_read(`BSG_REG_STATUS, rd);
		chk_word(rd & 32'h00000001, 32'h00000001);
		reg_write(`BSG_REG_MASK, 32'h00000000);
		settle(2);
		chk_pin(irq, 1'h0);
		reg_write(`BSG_REG_MASK, 32'h00000001);
		reg_write(`BSG_REG_STATUS, 32'h00000001);
		settle(2);
		chk_pin(irq, 1'h0);
		reg_write(8'h10, 32'hFFFFFFFF);
		reg_read(8'h10, rd);
		chk_word(rd, 32'h00000000);
		// Far-side misuse is only flagged: a short service pulse, a
		// controller read and a downstream error each set a status bit.
		i_bsg_up_model.svc_pulse(8);
		i_bsg_up_model.ctl_read();
		down_error_n <= 1'h0;
		settle(8);
		reg_read(`BSG_REG_STATUS, rd);
		chk_word(rd, 32'h00000038);
		chk_pin(xbar_reset, 1'h0);
		reg_write(`BSG_REG_STATUS, 32'h0000003F);
		down_error_n <= 1'h1;
		slot0_error <= 1'h0;
		reg_write(`BSG_REG_CTRL, 32'h00000001);
		settle(6);
		chk_pin(front_row_error_lamp & back_row_error_lamp, 1'h1);
		reg_read(`BSG_REG_STATE, rd);
		chk_word(rd, 32'h00000007);
		close_out();
	end
endmodule
